// ---- core/txduc_chain.sv ----
`timescale 1ns/1ps
module txduc_chain
	import txduc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic txInputDataClock,
	input wire txduc_iq_t txSample,
	input wire txduc_cfg_t cfg,
	input wire logic syncStrobe,
	output txduc_dac_t dacOut
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
		if (v > 40'(TXDUC_SMAX))
			return 16'(TXDUC_SMAX);
		if (v < 40'(TXDUC_SMIN))
			return 16'(TXDUC_SMIN);
		return v[15:0];
	endfunction

	function automatic logic signed [15:0] negSat(input logic signed [15:0] v);
		return sat16(-40'(v));
	endfunction

	function automatic logic signed [15:0] sinLut(input logic [5:0] ph);
		logic signed [15:0] v;
		v = ph[4] ? 16'(TXDUC_SIN_LUT[16 - 32'(ph[3:0])]) : 16'(TXDUC_SIN_LUT[ph[3:0]]);
		return ph[5] ? -v : v;
	endfunction

	// ---------------------------------------------------------------
	// link side: capture each input word and flag it with a toggle
	// ---------------------------------------------------------------
	txduc_iq_t linkWord;
	logic linkToggle;

	// word stays put for a whole input period, long enough for the toggle to cross
	always_ff @(posedge txInputDataClock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			linkWord <= '0;
			linkToggle <= 1'b0;
		end
		else
		begin
			linkWord <= txSample;
			linkToggle <= ~linkToggle;
		end
	end

	// ---------------------------------------------------------------
	// converter side: toggle synchroniser and word capture
	// ---------------------------------------------------------------
	logic togSync1;
	logic togSync2;
	logic togSeen;
	txduc_iq_t holdWord;
	txduc_cfg_t cfgReg;

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			togSync1 <= 1'b0;
			togSync2 <= 1'b0;
			togSeen <= 1'b0;
			holdWord <= '0;
		end
		else
		begin
			togSync1 <= linkToggle;
			togSync2 <= togSync1;
			togSeen <= togSync2;
			if (togSync2 != togSeen)
				holdWord <= linkWord;
		end
	end

	// settings register; every stage comes up low-pass and gain unity
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			cfgReg <= TXDUC_CFG_RESET;
		else
			cfgReg <= cfg;
	end

	// ---------------------------------------------------------------
	// rate phase: 0..1 in 2x, 0..3 in 4x, realigned by sync
	// ---------------------------------------------------------------
	logic [1:0] ratePh;

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			ratePh <= 2'h0;
		else if (syncStrobe)
			ratePh <= 2'h0;
		else if (cfgReg.interpBy4)
			ratePh <= ratePh + 2'h1;
		else
			ratePh <= {1'b0, ~ratePh[0]};
	end

	// ---------------------------------------------------------------
	// half-band interpolators, one pair of stages per channel
	// ---------------------------------------------------------------
	txduc_iq_t cmOut;

	for (genvar ch = 0; ch < 2; ch++)
	begin : g_ch
		logic signed [15:0] chIn;
		logic signed [15:0] line1 [2 * TXDUC_FIR1_PAIRS];
		logic signed [15:0] line2 [2 * TXDUC_FIR2_PAIRS];
		logic signed [15:0] lineS [2 * TXDUC_SINC_PAIRS + 1];
		logic signed [39:0] sum1;
		logic signed [39:0] sum2;
		logic signed [39:0] sumS;
		logic signed [15:0] out1;
		logic signed [15:0] out2;
		logic signed [15:0] interpOut;
		logic signed [15:0] sincOut;

		assign chIn = (ch == 0) ? holdWord.a : holdWord.b;
		assign interpOut = cfgReg.interpBy4 ? out2 : out1;

		// odd-phase sums for both half-bands, zero taps skipped, centre tap gives the even phase; full 9-tap sum for the inverse sinc
		always_comb
		begin
			sum1 = '0;
			for (int j = 0; j < TXDUC_FIR1_PAIRS; j++)
				sum1 = sum1 + 40'(TXDUC_FIR1_COEF[j]) *
					(40'(line1[j]) + 40'(line1[2 * TXDUC_FIR1_PAIRS - 1 - j]));
			sum2 = '0;
			for (int j = 0; j < TXDUC_FIR2_PAIRS; j++)
				sum2 = sum2 + 40'(TXDUC_FIR2_COEF[j]) *
					(40'(line2[j]) + 40'(line2[2 * TXDUC_FIR2_PAIRS - 1 - j]));
			sumS = 40'(TXDUC_SINC_COEF[TXDUC_SINC_PAIRS]) * 40'(lineS[TXDUC_SINC_PAIRS]);
			for (int j = 0; j < TXDUC_SINC_PAIRS; j++)
				sumS = sumS + 40'(TXDUC_SINC_COEF[j]) *
					(40'(lineS[j]) + 40'(lineS[2 * TXDUC_SINC_PAIRS - j]));
		end

		// first stage: odd output and shift at phase 0, even output at phase 1 in 2x or phase 2 in 4x
		always_ff @(posedge ref_clk or negedge arst_n)
		begin
			if (!arst_n)
			begin
				for (int k = 0; k < 2 * TXDUC_FIR1_PAIRS; k++)
					line1[k] <= '0;
				out1 <= '0;
			end
			else if (ratePh == 2'h0)
			begin
				line1[0] <= chIn;
				for (int k = 1; k < 2 * TXDUC_FIR1_PAIRS; k++)
					line1[k] <= line1[k - 1];
				// high-pass flips the sign of every off-centre tap
				out1 <= cfgReg.highPass[ch * 2] ? sat16(-(sum1 >>> TXDUC_FIR1_SHIFT)) :
					sat16(sum1 >>> TXDUC_FIR1_SHIFT);
			end
			else if (!cfgReg.interpBy4 || ratePh == 2'h2)
				out1 <= line1[TXDUC_FIR1_PAIRS];
		end

		// second stage runs only in 4x and is frozen in 2x to save toggling
		always_ff @(posedge ref_clk or negedge arst_n)
		begin
			if (!arst_n)
			begin
				for (int k = 0; k < 2 * TXDUC_FIR2_PAIRS; k++)
					line2[k] <= '0;
				out2 <= '0;
			end
			else if (cfgReg.interpBy4 && ratePh[0])
			begin
				line2[0] <= out1;
				for (int k = 1; k < 2 * TXDUC_FIR2_PAIRS; k++)
					line2[k] <= line2[k - 1];
				out2 <= cfgReg.highPass[ch * 2 + 1] ? sat16(-(sum2 >>> TXDUC_FIR2_SHIFT)) :
					sat16(sum2 >>> TXDUC_FIR2_SHIFT);
			end
			else if (cfgReg.interpBy4)
				out2 <= line2[TXDUC_FIR2_PAIRS];
		end

		// inverse sinc at full rate; bypass keeps the same delay
		always_ff @(posedge ref_clk or negedge arst_n)
		begin
			if (!arst_n)
			begin
				for (int k = 0; k < 2 * TXDUC_SINC_PAIRS + 1; k++)
					lineS[k] <= '0;
				sincOut <= '0;
			end
			else
			begin
				lineS[0] <= (ch == 0) ? cmOut.a : cmOut.b;
				for (int k = 1; k < 2 * TXDUC_SINC_PAIRS + 1; k++)
					lineS[k] <= lineS[k - 1];
				// no input back-off here: the driver must leave headroom
				sincOut <= cfgReg.invSincOn ? sat16(sumS >>> TXDUC_SINC_SHIFT) :
					lineS[TXDUC_SINC_PAIRS];
			end
		end
	end

	// ---------------------------------------------------------------
	// fine mixer with numeric oscillator
	// ---------------------------------------------------------------
	logic [31:0] ncoAcc;
	logic [31:0] ncoFreqAct;
	logic signed [15:0] ncoCos;
	logic signed [15:0] ncoSin;
	logic signed [39:0] mixI;
	logic signed [39:0] mixQ;
	txduc_iq_t fmOut;

	// words only take hold on sync so all chips start in step
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ncoAcc <= 32'h0000_0000;
			ncoFreqAct <= 32'h0000_0000;
		end
		else if (syncStrobe)
		begin
			ncoFreqAct <= cfgReg.ncoFreq;
			ncoAcc <= {cfgReg.ncoPhase, TXDUC_ACC_LOW'(0)};
		end
		else
			ncoAcc <= ncoAcc + ncoFreqAct;
	end

	// short table keeps area down at the cost of spur level
	assign ncoSin = sinLut(ncoAcc[31:26]);
	assign ncoCos = sinLut(ncoAcc[31:26] + 6'h10);
	assign mixI = (40'(g_ch[0].interpOut) * 40'(ncoCos) -
		40'(g_ch[1].interpOut) * 40'(ncoSin)) >>> TXDUC_SIN_SHIFT;
	assign mixQ = (40'(g_ch[0].interpOut) * 40'(ncoSin) +
		40'(g_ch[1].interpOut) * 40'(ncoCos)) >>> TXDUC_SIN_SHIFT;

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			fmOut <= '0;
		else
		begin
			fmOut.a <= sat16(mixI);
			fmOut.b <= sat16(mixQ);
		end
	end

	// ---------------------------------------------------------------
	// coarse mixer, phase restarted by sync
	// ---------------------------------------------------------------
	logic [1:0] cmixPh;

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			cmixPh <= 2'h0;
		else if (syncStrobe)
			cmixPh <= 2'h0;
		else
			cmixPh <= cmixPh + 2'h1;
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			cmOut <= '0;
		else
			unique case (cfgReg.cmixMode)
				TXDUC_COARSE_QUARTER_RATE_MIXER_PASS:
					cmOut <= fmOut;
				TXDUC_COARSE_QUARTER_RATE_MIXER_HALF:
					cmOut <= cmixPh[0] ? {negSat(fmOut.a), negSat(fmOut.b)} : fmOut;
				TXDUC_COARSE_QUARTER_RATE_MIXER_PLUSQ:
					unique case (cmixPh)
						2'h0: cmOut <= fmOut;
						2'h1: cmOut <= {negSat(fmOut.b), fmOut.a};
						2'h2: cmOut <= {negSat(fmOut.a), negSat(fmOut.b)};
						2'h3: cmOut <= {fmOut.b, negSat(fmOut.a)};
					endcase
				TXDUC_COARSE_QUARTER_RATE_MIXER_MINUSQ:
					unique case (cmixPh)
						2'h0: cmOut <= fmOut;
						2'h1: cmOut <= {fmOut.b, negSat(fmOut.a)};
						2'h2: cmOut <= {negSat(fmOut.a), negSat(fmOut.b)};
						2'h3: cmOut <= {negSat(fmOut.b), fmOut.a};
					endcase
			endcase
	end

	// ---------------------------------------------------------------
	// quadrature correction and offset
	// ---------------------------------------------------------------
	logic signed [39:0] qmcI;
	logic signed [39:0] qmcQ;
	txduc_iq_t qmcOut;
	logic signed [12:0] offActA;
	logic signed [12:0] offActB;
	logic signed [15:0] offSumA;
	logic signed [15:0] offSumB;

	// gain over 1024 folded into the phase term's 4096 scale
	// unsigned gain is widened as a signed operand, else the product loses the sample sign
	assign qmcI = ((40'(g_ch[0].sincOut) * 40'($signed({1'b0, cfgReg.gainA}))
		<<< TXDUC_GAIN_SHIFT) + 40'(g_ch[1].sincOut) * 40'($signed(cfgReg.phaseCorr)))
		>>> TXDUC_QMC_SHIFT;
	assign qmcQ = (40'(g_ch[1].sincOut) * 40'($signed({1'b0, cfgReg.gainB}))
		<<< TXDUC_GAIN_SHIFT) >>> TXDUC_QMC_SHIFT;

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			qmcOut <= '0;
		else
		begin
			qmcOut.a <= sat16(qmcI);
			qmcOut.b <= sat16(qmcQ);
		end
	end

	// offsets follow the settings at once or wait for sync
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			offActA <= '0;
			offActB <= '0;
		end
		else if (!cfgReg.offsetSyncNeeded || syncStrobe)
		begin
			offActA <= cfgReg.offsetA;
			offActB <= cfgReg.offsetB;
		end
	end

	// data keeps four fraction bits, so offset lsb lines up with data lsb
	assign offSumA = sat16(40'(qmcOut.a) + 40'(offActA));
	assign offSumB = sat16(40'(qmcOut.b) + 40'(offActB));

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			dacOut <= '0;
		else
		begin
			dacOut.a <= offSumA[15:4];
			dacOut.b <= offSumB[15:4];
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	property p_stage2_idle;
		@(posedge ref_clk) disable iff (!arst_n)
		!cfgReg.interpBy4 |=> $stable(g_ch[0].out2) && $stable(g_ch[1].out2);
	endproperty
	a_stage2_idle: assert property (p_stage2_idle) else $error("second stage moved in 2x");

	property p_nco_step;
		@(posedge ref_clk) disable iff (!arst_n)
		!syncStrobe |=> ncoAcc == $past(ncoAcc) + $past(ncoFreqAct);
	endproperty
	a_nco_step: assert property (p_nco_step) else $error("accumulator step wrong");

	property p_sync_load;
		@(posedge ref_clk) disable iff (!arst_n)
		syncStrobe |=> ncoAcc[31:12] == $past(cfgReg.ncoPhase) &&
			ncoFreqAct == $past(cfgReg.ncoFreq) ##1 ncoAcc == $past(ncoAcc) + ncoFreqAct;
	endproperty
	a_sync_load: assert property (p_sync_load) else $error("sync load wrong");

	property p_coarse_quarter_rate_mixer_pass;
		@(posedge ref_clk) disable iff (!arst_n)
		cfgReg.cmixMode == TXDUC_COARSE_QUARTER_RATE_MIXER_PASS |=> cmOut == $past(fmOut);
	endproperty
	a_coarse_quarter_rate_mixer_pass: assert property (p_coarse_quarter_rate_mixer_pass) else $error("coarse pass altered data");

	property p_coarse_quarter_rate_mixer_half;
		@(posedge ref_clk) disable iff (!arst_n)
		cfgReg.cmixMode == TXDUC_COARSE_QUARTER_RATE_MIXER_HALF && cmixPh[0] |=>
			cmOut.a == negSat($past(fmOut.a)) && cmOut.b == negSat($past(fmOut.b));
	endproperty
	a_coarse_quarter_rate_mixer_half: assert property (p_coarse_quarter_rate_mixer_half) else $error("half-rate negate missing");

	property p_coarse_quarter_rate_mixer_quarter;
		@(posedge ref_clk) disable iff (!arst_n)
		cfgReg.cmixMode == TXDUC_COARSE_QUARTER_RATE_MIXER_PLUSQ && cmixPh == 2'h1 |=>
			cmOut.a == negSat($past(fmOut.b)) && cmOut.b == $past(fmOut.a);
	endproperty
	a_coarse_quarter_rate_mixer_quarter: assert property (p_coarse_quarter_rate_mixer_quarter) else $error("quarter rotate wrong");

	property p_off_now;
		@(posedge ref_clk) disable iff (!arst_n)
		!cfgReg.offsetSyncNeeded |=> offActA == $past(cfgReg.offsetA) &&
			offActB == $past(cfgReg.offsetB);
	endproperty
	a_off_now: assert property (p_off_now) else $error("offset not applied at once");

	property p_off_hold;
		@(posedge ref_clk) disable iff (!arst_n)
		cfgReg.offsetSyncNeeded && !syncStrobe |=> $stable(offActA) && $stable(offActB);
	endproperty
	a_off_hold: assert property (p_off_hold) else $error("offset changed without sync");

	c_interp4: cover property (@(posedge ref_clk) disable iff (!arst_n)
		cfgReg.interpBy4 && togSync2 != togSeen);
	c_sync: cover property (@(posedge ref_clk) disable iff (!arst_n)
		syncStrobe && cfgReg.offsetSyncNeeded);
	c_minusq: cover property (@(posedge ref_clk) disable iff (!arst_n)
		cfgReg.cmixMode == TXDUC_COARSE_QUARTER_RATE_MIXER_MINUSQ && cmixPh == 2'h3);

endmodule // txduc_chain

// ---- core/txduc_pkg.sv ----
// Notes on behaviour
// - transmit samples are interpolated by two or four with half-band filters
// - two stages per channel; only the first works in 2x, both cascade in 4x
// - each stage per channel is low-pass or high-pass; low-pass after reset
// - first stage: symmetric 43-tap half-band, outer taps up to 10365, centre 16384
// - second stage: symmetric 19-tap half-band, outer taps up to 2525, centre 4096
// - fine mixer: I = A cos - B sin, Q = A sin + B cos
// - oscillator has a 32-bit frequency word and a 20-bit phase offset
// - frequency spans plus or minus half the rate in steps of rate over 2^32
// - coarse mode 00 passes A and B; mode 01 negates every second sample
// - coarse modes 10 and 11 rotate by a quarter of the rate each way
// - 9-tap inverse sinc filter with gain above unity, bypassable
// - I and Q gains are 11-bit unsigned over 1024; 1024 is unity
// - 10-bit phase term times Q sample is added to I, range one eighth
// - A and B offsets are 13-bit signed, in sixteenths of an output step
// - offset added last before conversion, aligned at the least significant bit
// - sync loads oscillator words and sets the accumulator to the phase offset
// - offsets apply at once unless sync is required, then only on sync
package txduc_pkg;

	// ---------------------------------------------------------------
	// widths and scaling
	// ---------------------------------------------------------------
	localparam int TXDUC_DW = 16;
	localparam int TXDUC_SMAX = 32767;
	localparam int TXDUC_SMIN = -32768;
	localparam int TXDUC_FIR1_PAIRS = 11;
	localparam int TXDUC_FIR1_SHIFT = 14;
	localparam int TXDUC_FIR2_PAIRS = 5;
	localparam int TXDUC_FIR2_SHIFT = 12;
	localparam int TXDUC_SINC_PAIRS = 4;
	localparam int TXDUC_SINC_SHIFT = 9;
	localparam int TXDUC_SIN_SHIFT = 14;
	localparam int TXDUC_GAIN_SHIFT = 2;
	localparam int TXDUC_QMC_SHIFT = 12;
	localparam int TXDUC_ACC_LOW = 12;

	// ---------------------------------------------------------------
	// coefficient tables, outermost tap first
	// ---------------------------------------------------------------
	localparam int TXDUC_FIR1_COEF [11] = '{12, -33, 73, -143, 254, -426, 685, -1090, 1781,
		-3286, 10365};
	localparam int TXDUC_FIR2_COEF [5] = '{11, -64, 224, -648, 2525};
	localparam int TXDUC_SINC_COEF [5] = '{1, -4, 13, -50, 592};
	// quarter sine wave in 17 steps, unity is 16384
	localparam int TXDUC_SIN_LUT [17] = '{0, 1606, 3196, 4756, 6270, 7723, 9102, 10394, 11585,
		12665, 13623, 14449, 15137, 15679, 16069, 16305, 16384};

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		TXDUC_COARSE_QUARTER_RATE_MIXER_PASS = 2'b00,
		TXDUC_COARSE_QUARTER_RATE_MIXER_HALF = 2'b01,
		TXDUC_COARSE_QUARTER_RATE_MIXER_PLUSQ = 2'b10,
		TXDUC_COARSE_QUARTER_RATE_MIXER_MINUSQ = 2'b11
	} txduc_coarse_quarter_rate_mixer_t;

	typedef struct packed {
		logic signed [15:0] a;
		logic signed [15:0] b;
	} txduc_iq_t;

	typedef struct packed {
		logic signed [11:0] a;
		logic signed [11:0] b;
	} txduc_dac_t;

	typedef struct packed {
		logic interpBy4;
		logic [3:0] highPass; // bit ch*2+stage
		logic [31:0] ncoFreq;
		logic [19:0] ncoPhase;
		txduc_coarse_quarter_rate_mixer_t cmixMode;
		logic invSincOn;
		logic [10:0] gainA;
		logic [10:0] gainB;
		logic [9:0] phaseCorr;
		logic [12:0] offsetA;
		logic [12:0] offsetB;
		logic offsetSyncNeeded;
	} txduc_cfg_t;

	localparam logic [10:0] TXDUC_GAIN_RESET = 11'h400;
	localparam txduc_cfg_t TXDUC_CFG_RESET = '{
		interpBy4: 1'b0,
		highPass: 4'h0,
		ncoFreq: 32'h0000_0000,
		ncoPhase: 20'h0_0000,
		cmixMode: TXDUC_COARSE_QUARTER_RATE_MIXER_PASS,
		invSincOn: 1'b0,
		gainA: TXDUC_GAIN_RESET,
		gainB: TXDUC_GAIN_RESET,
		phaseCorr: 10'h000,
		offsetA: 13'h0000,
		offsetB: 13'h0000,
		offsetSyncNeeded: 1'b0
	};

endpackage

// ---- dv/txduc_bb_source.sv ----
`timescale 1ns/1ps
module txduc_bb_source
	import txduc_pkg::*;
(
	input wire logic txInputDataClock,
	input wire logic arst_n,
	input wire logic signed [15:0] levelA,
	input wire logic signed [15:0] levelB,
	input wire logic allowFull,
	output txduc_iq_t txSample
);
	// ----------
	// baseband sample source
	// ----------
	localparam int BACKOFF = 29541;

	// backs off from full scale so the inverse sinc cannot clip up to a quarter of the rate, unless the bench asks otherwise
	function automatic logic signed [15:0] limit(input logic signed [15:0] v, input logic full);
		if (full || (v <= BACKOFF && v >= -BACKOFF))
			return v;
		return (v > 0) ? 16'sh7365 : -16'sh7365;
	endfunction

	// new pair just after each rising link edge, held until the next one
	always @(posedge txInputDataClock or negedge arst_n)
		if (!arst_n)
			txSample <= '0;
		else
			txSample <= #1 '{limit(levelA, allowFull), limit(levelB, allowFull)};
endmodule // txduc_bb_source

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench
	import txduc_pkg::*;
	;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic txInputDataClock = 1'b0;
	logic syncStrobe = 1'b0;
	logic allowFull = 1'b0;
	logic signed [15:0] srcA = '0;
	logic signed [15:0] srcB = '0;
	txduc_iq_t txSample;
	txduc_cfg_t cfg = TXDUC_CFG_RESET;
	txduc_dac_t dacOut;
	int errors = 0;
	int checks = 0;
	int cycles = 0;
	int tests = 0;
	logic signed [11:0] pa [4];
	logic signed [11:0] pb [4];
	int hpTab [6] = '{0, 1, 2, 2, 8, 4};
	bit by4Tab [6] = '{0, 0, 0, 1, 1, 1};

	// ----------
	// clocks, design and source
	// ----------
	always #5 ref_clk = ~ref_clk;

	// odd start offset keeps the link clock unrelated in phase to ref_clk
	// link is slower than ref/2 and ref/4, so each held level is simply reused
	initial
	begin
		#3.3;
		forever #24 txInputDataClock = ~txInputDataClock;
	end

	txduc_chain i_dut (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.txInputDataClock(txInputDataClock),
		.txSample(txSample),
		.cfg(cfg),
		.syncStrobe(syncStrobe),
		.dacOut(dacOut)
	);

	txduc_bb_source i_src (
		.txInputDataClock(txInputDataClock),
		.arst_n(arst_n),
		.levelA(srcA),
		.levelB(srcB),
		.allowFull(allowFull),
		.txSample(txSample)
	);

	// ----------
	// helpers
	// ----------
	// cuts a hang short; the full run needs about 11000 cycles
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic check(input logic [11:0] seen, input logic [11:0] want);
		checks++;
		if (seen !== want)
		begin
			errors++;
			$display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	function automatic longint sat(input longint v);
		return (v > TXDUC_SMAX) ? TXDUC_SMAX : (v < TXDUC_SMIN) ? TXDUC_SMIN : v;
	endfunction

	// converter word: saturate, add the lsb-aligned offset, saturate, keep the top 12 bits
	function automatic logic signed [11:0] to_dac(input longint v, input longint off);
		return 12'(sat(sat(v) + off) >>> 4);
	endfunction

	// settings and levels change off the sampling edge; sync only after cfg has been taken
	task automatic apply(input txduc_cfg_t c, input logic signed [15:0] a,
		input logic signed [15:0] b, input logic sync);
		@(negedge ref_clk);
		cfg = c;
		srcA = a;
		srcB = b;
		repeat (3) @(negedge ref_clk);
		syncStrobe = sync;
		@(negedge ref_clk);
		syncStrobe = 1'b0;
		repeat (300) @(negedge ref_clk);
	endtask

	// expected words for a coarse mode, optionally turned by a static quarter rotation
	task automatic pattern(input int mode, input int rot, input logic signed [11:0] a,
		input logic signed [11:0] b);
		int r;
		for (int i = 0; i < 4; i++)
		begin
			r = (mode == 0) ? 0 : (mode == 1) ? (i % 2) * 2 : (mode == 2) ? i : (4 - i) % 4;
			r = (r + rot) % 4;
			pa[i] = (r == 0) ? a : (r == 1) ? -b : (r == 2) ? -a : b;
			pb[i] = (r == 0) ? b : (r == 1) ? a : (r == 2) ? -b : -a;
		end
	endtask

	// four words against the pattern, at whichever of its phases lines up with the output
	task automatic check_seq();
		txduc_dac_t seen [4];
		int k;
		k = 0;
		for (int i = 0; i < 4; i++)
		begin
			@(negedge ref_clk);
			seen[i] = dacOut;
		end
		for (int r = 0; r < 4; r++)
			if (seen[0] === {pa[r], pb[r]} && seen[1] === {pa[(r + 1) % 4], pb[(r + 1) % 4]})
				k = r;
		for (int i = 0; i < 4; i++)
		begin
			check(seen[i].a, pa[(k + i) % 4]);
			check(seen[i].b, pb[(k + i) % 4]);
		end
		tests++;
		$display("test %0d done at %0t", tests, $time);
	endtask

	// ----------
	// main sequence
	// ----------
	initial
	begin
		txduc_cfg_t c;
		logic signed [15:0] a;
		logic signed [15:0] b;
		longint x, y, g;
		void'($urandom(32'hd767));
		repeat (8) @(negedge ref_clk);
		arst_n = 1'b1;
		a = 16'sh0C80;
		b = -16'sh0640;

		// interpolation by two and four, each stage low-pass or high-pass per channel
		for (int t = 0; t < 6; t++)
		begin
			c = TXDUC_CFG_RESET;
			c.interpBy4 = by4Tab[t];
			c.highPass = 4'(hpTab[t]);
			apply(c, a, b, 1'b0);
			for (int i = 0; i < 4; i++)
			begin
				pa[i] = (c.highPass[c.interpBy4] && i % 2) ? to_dac(-a, 0) : to_dac(a, 0);
				pb[i] = (c.highPass[2 + c.interpBy4] && i % 2) ? to_dac(-b, 0) : to_dac(b, 0);
				// high-pass first stage in 4x lands on the second stage's band edge
				if (c.interpBy4 && c.highPass[0])
					pa[i] = (i % 2) ? 12'sh000 : (i / 2) ? to_dac(-a, 0) : to_dac(a, 0);
				if (c.interpBy4 && c.highPass[2])
					pb[i] = (i % 2) ? 12'sh000 : (i / 2) ? to_dac(-b, 0) : to_dac(b, 0);
			end
			check_seq();
		end

		// every coarse mixing mode
		for (int m = 0; m < 4; m++)
		begin
			c = TXDUC_CFG_RESET;
			c.cmixMode = txduc_coarse_quarter_rate_mixer_t'(m);
			apply(c, a, b, 1'b0);
			pattern(m, 0, to_dac(a, 0), to_dac(b, 0));
			check_seq();
		end

		// inverse sinc gain at half rate, once in range and once driven into saturation
		g = TXDUC_SINC_COEF[4];
		for (int k = 0; k < 4; k++)
			g += 2 * TXDUC_SINC_COEF[k] * ((k % 2) ? -1 : 1);
		allowFull = 1'b1;
		for (int s = 0; s < 2; s++)
		begin
			c = TXDUC_CFG_RESET;
			c.cmixMode = TXDUC_COARSE_QUARTER_RATE_MIXER_HALF;
			c.invSincOn = 1'b1;
			apply(c, s ? 16'sh7530 : 16'sh2000, 16'sh0000, 1'b0);
			x = (longint'(srcA) * g) >>> TXDUC_SINC_SHIFT;
			for (int i = 0; i < 4; i++)
			begin
				pa[i] = to_dac(i % 2 ? -x : x, 0);
				pb[i] = 12'sh000;
			end
			check_seq();
		end
		allowFull = 1'b0;

		// gain, phase and offset correction with random settings, corners first
		for (int n = 0; n < 8; n++)
		begin
			c = TXDUC_CFG_RESET;
			c.gainA = n ? 11'($urandom) : 11'h7FF;
			c.gainB = 11'($urandom);
			c.phaseCorr = 10'($urandom);
			c.offsetA = n ? 13'($urandom) : 13'h0FFF;
			c.offsetB = n ? 13'($urandom) : 13'h1000;
			apply(c, n ? 16'($signed(15'($urandom))) : 16'sh7365,
				n ? 16'($signed(15'($urandom))) : -16'sh7365, 1'b0);
			x = (longint'(srcA) * longint'(c.gainA) * 4 + longint'(srcB) * $signed(c.phaseCorr))
				>>> TXDUC_QMC_SHIFT;
			y = (longint'(srcB) * longint'(c.gainB)) >>> (TXDUC_QMC_SHIFT - TXDUC_GAIN_SHIFT);
			pattern(0, 0, to_dac(x, $signed(c.offsetA)), to_dac(y, $signed(c.offsetB)));
			check_seq();
		end

		// offsets wait for a sync pulse once sync is required
		c = TXDUC_CFG_RESET;
		apply(c, a, b, 1'b0);
		c.offsetSyncNeeded = 1'b1;
		c.offsetA = 13'h0640;
		c.offsetB = 13'h1CE0;
		apply(c, a, b, 1'b0);
		pattern(0, 0, to_dac(a, 0), to_dac(b, 0));
		check_seq();
		apply(c, a, b, 1'b1);
		pattern(0, 0, to_dac(a, $signed(c.offsetA)), to_dac(b, $signed(c.offsetB)));
		check_seq();

		// oscillator phase quarters, then plus and minus a quarter of the rate
		for (int p = 1; p <= 6; p++)
		begin
			c = TXDUC_CFG_RESET;
			c.ncoPhase = (p < 5) ? 20'(p * 20'h4_0000) : 20'h0_0000;
			c.ncoFreq = (p == 5) ? 32'h4000_0000 : (p == 6) ? 32'hC000_0000 : 32'h0000_0000;
			apply(c, a, b, 1'b0);
			if (p < 6)
			begin
				pattern(0, (p - 1) % 4, to_dac(a, 0), to_dac(b, 0));
				check_seq();
			end
			apply(c, a, b, 1'b1);
			pattern((p < 5) ? 0 : p - 3, (p < 5) ? p % 4 : 0, to_dac(a, 0), to_dac(b, 0));
			check_seq();
		end
		close_out();
	end
endmodule // testbench
